/* File: hw/dba_pkg.sv */
// package: constants and types for the dma buffer arbiter
package dba_pkg;
    localparam int BUF_AW = 13;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int IDX_DIV = 4;
    localparam int IDX_CW = 2;
    localparam int CTRL_W = 8;
    localparam int STAT_W = 8;
    localparam int RG_DELAY_NS = 200;
    localparam int CLK_NS = 20;
    localparam int RG_DELAY_CYC = (RG_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RG_CW = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    typedef enum logic [1:0] {
        DBA_IDLE = 2'b00,
        DBA_LOCAL = 2'b01,
        DBA_PROC = 2'b10,
        DBA_REMOTE = 2'b11
    } dba_grant_t;
endpackage

/* File: hw/dba_fifo_if.sv */
// interface: valid/ready byte stream into the fifo
`timescale 1ns/1ns
interface dba_fifo_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: hw/dba_fifo.sv */
// module: parameterised valid/ready fifo
`timescale 1ns/1ns
module dba_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // fill side
    dba_fifo_if.snk in_if,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0] cnt_r;
    logic push, pop;
    assign in_if.ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_if.data;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: hw/dba_arbiter.sv */
// module: dma bus arbiter, byte steering, eom stop, led divider, read gate delay
`timescale 1ns/1ns
// How it works
// RULE1: detector watches host bytes and flags arbiter on an eoi-tagged byte.
// RULE2: after eoi, no more host-to-buffer movement until the remote request ends.
// RULE3: arbiter alone grants the bus; local beats processor beats remote.
// RULE4: local is disc controller, processor is micro, remote is host chip.
// RULE5: two buffers, zero and one, each 8k by 8 bits.
// RULE6: host transfers move one byte per bus cycle.
// RULE7: odd host bytes go to buffer one, even bytes to buffer zero.
// RULE8: buffer one transceiver is off for every even byte.
// RULE9: disc controller transfers are 16 bits, both buffers enabled together.
// RULE10: bus split into upper and lower byte lanes.
// RULE11: read gate is delayed so it never lands on a write splice.
// RULE12: drive index pulse clocks a divide-by-four counter.
// RULE13: divider output drives green and red panel lamps.
// RULE14: micro control bits drive drive signals; status bits sample them.
// RULE15: odd/even follows lsb of running byte index, starting at zero.
// RULE16: 16-bit: buffer zero on lower lane, buffer one on upper lane.
module dba_arbiter
    import dba_pkg::*;
#(
    parameter int RG_CYC = RG_DELAY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // local requester (disc data controller)
    input wire logic local_req,
    input wire logic local_we,
    input wire logic [BUF_AW-1:0] local_addr,
    input wire logic [WORD_W-1:0] local_wdata,
    output logic local_gnt,
    output logic [WORD_W-1:0] local_rdata,
    output logic local_ack,
    // processor requester
    input wire logic proc_req,
    input wire logic proc_we,
    input wire logic [BUF_AW:0] proc_addr,
    input wire logic [BYTE_W-1:0] proc_wdata,
    output logic proc_gnt,
    output logic [BYTE_W-1:0] proc_rdata,
    output logic proc_ack,
    // remote requester (host chip), write stream
    input wire logic remote_req,
    input wire logic [BUF_AW-1:0] remote_base,
    input wire logic remote_valid,
    input wire logic [BYTE_W-1:0] remote_data,
    input wire logic remote_eoi,
    output logic remote_ready,
    output logic remote_gnt,
    output logic remote_eom,
    // buffer enables and lane transceivers
    output logic buf0_en,
    output logic buf1_en,
    output logic xcvr1_en,
    // drive interface
    input wire logic index_pin,
    input wire logic read_gate_req,
    input wire logic write_gate,
    input wire logic [CTRL_W-1:0] ctrl_wdata,
    input wire logic ctrl_we,
    input wire logic [STAT_W-1:0] drive_status_pin,
    output logic [CTRL_W-1:0] drive_ctrl,
    output logic [STAT_W-1:0] drive_status,
    output logic read_gate,
    output logic led_green,
    output logic led_red
);
    logic [BYTE_W-1:0] buf0 [1<<BUF_AW]; // [RULE5]
    logic [BYTE_W-1:0] buf1 [1<<BUF_AW];
    dba_grant_t gnt_r, gnt_nxt;
    logic eom_r;
    logic [BUF_AW:0] idx_r;
    dba_fifo_if #(.W(BYTE_W+1)) fin();
    logic f_valid, f_ready;
    logic [BYTE_W:0] f_data;
    logic idx_s1_r, idx_s2_r, idx_d_r;
    logic [IDX_CW-1:0] idx_cnt_r;
    logic [STAT_W-1:0] st_s1_r, st_s2_r;
    logic rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
    logic [RG_CW-1:0] rg_cnt_r;
    logic host_odd;
    logic host_go;
    logic host_push;
    logic eom_nxt;
    localparam int HCW = $clog2(FIFO_DEPTH) + 1;
    logic [HCW-1:0] hcnt_r, hcnt_nxt;

    // host stream buffered ahead of the bus; eom closes the intake
    assign fin.valid = remote_valid && remote_ready; // [RULE2]
    assign fin.data = {remote_eoi, remote_data};
    assign host_push = fin.valid && fin.ready;
    dba_fifo #(.W(BYTE_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_if(fin),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    function automatic dba_grant_t pick(input logic l, input logic p, input logic r);
        if (l) begin
            return DBA_LOCAL;
        end else if (p) begin
            return DBA_PROC;
        end else if (r) begin
            return DBA_REMOTE;
        end
        return DBA_IDLE;
    endfunction

    // byte address lsb picks buffer one
    function automatic logic odd_lane(input logic [BUF_AW:0] a);
        return a[0];
    endfunction

    always_comb begin
        gnt_nxt = pick(local_req, proc_req, remote_req && !eom_r); // [RULE3] [RULE2]
    end

    assign host_go = (gnt_r == DBA_REMOTE) && f_valid && !eom_r;
    assign f_ready = host_go;
    assign host_odd = idx_r[0]; // [RULE15]

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gnt_r <= DBA_IDLE;
        end else begin
            gnt_r <= gnt_nxt;
        end
    end

    // grant flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            local_gnt <= 1'b0;
            proc_gnt <= 1'b0;
            remote_gnt <= 1'b0;
        end else begin
            local_gnt <= (gnt_nxt == DBA_LOCAL);
            proc_gnt <= (gnt_nxt == DBA_PROC);
            remote_gnt <= (gnt_nxt == DBA_REMOTE);
        end
    end

    // next eom state: the eoi byte wins over a dropped request
    always_comb begin
        eom_nxt = eom_r;
        if (host_go && f_data[BYTE_W]) begin
            eom_nxt = 1'b1; // [RULE1]
        end else if (!remote_req) begin
            eom_nxt = 1'b0;
        end
    end

    // mirror of the fifo fill, same push and pop as the fifo sees
    assign hcnt_nxt = hcnt_r + HCW'(host_push) - HCW'(host_go);

    // eom latch, shown on the pin in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eom_r <= 1'b0;
            remote_eom <= 1'b0;
        end else begin
            eom_r <= eom_nxt;
            remote_eom <= eom_nxt; // [RULE1]
        end
    end

    // intake ready from a flop: next fill below depth and no eom
    // ready never exceeds the fifo's own ready, so no byte is lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hcnt_r <= '0;
            remote_ready <= 1'b0;
        end else begin
            hcnt_r <= hcnt_nxt;
            remote_ready <= (hcnt_nxt != HCW'(FIFO_DEPTH)) && !eom_nxt; // [RULE2]
        end
    end

    // running byte index of the host transfer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_r <= '0;
        end else begin
            if (!remote_req) begin
                idx_r <= '0; // [RULE15]
            end else if (host_go) begin
                idx_r <= idx_r + 1'b1;
            end
        end
    end

    // buffer rams: even bytes buffer zero, odd bytes buffer one
    always_ff @(posedge clk) begin
        if (gnt_r == DBA_LOCAL && local_we) begin
            buf0[local_addr] <= local_wdata[BYTE_W-1:0]; // [RULE9] [RULE16] [RULE10]
            buf1[local_addr] <= local_wdata[WORD_W-1:BYTE_W];
        end else if (gnt_r == DBA_PROC && proc_we) begin
            if (odd_lane(proc_addr)) begin
                buf1[proc_addr[BUF_AW:1]] <= proc_wdata; // [RULE4]
            end else begin
                buf0[proc_addr[BUF_AW:1]] <= proc_wdata;
            end
        end else if (host_go) begin
            if (host_odd) begin
                buf1[remote_base + idx_r[BUF_AW:1]] <= f_data[BYTE_W-1:0]; // [RULE7] [RULE6]
            end else begin
                buf0[remote_base + idx_r[BUF_AW:1]] <= f_data[BYTE_W-1:0];
            end
        end
    end

    // read data and acks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            local_rdata <= '0;
            local_ack <= 1'b0;
            proc_rdata <= '0;
            proc_ack <= 1'b0;
        end else begin
            local_ack <= (gnt_r == DBA_LOCAL);
            proc_ack <= (gnt_r == DBA_PROC);
            if (gnt_r == DBA_LOCAL) begin
                local_rdata <= {buf1[local_addr], buf0[local_addr]}; // [RULE16]
            end
            if (gnt_r == DBA_PROC) begin
                proc_rdata <= odd_lane(proc_addr) ? buf1[proc_addr[BUF_AW:1]] : buf0[proc_addr[BUF_AW:1]];
            end
        end
    end

    // buffer enables and lane transceiver, one cycle behind the access
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf0_en <= 1'b0;
            buf1_en <= 1'b0;
            xcvr1_en <= 1'b0;
        end else begin
            case (gnt_r)
                DBA_LOCAL: begin
                    buf0_en <= 1'b1; // [RULE9]
                    buf1_en <= 1'b1;
                    xcvr1_en <= 1'b1;
                end
                DBA_PROC: begin
                    buf0_en <= !odd_lane(proc_addr);
                    buf1_en <= odd_lane(proc_addr);
                    xcvr1_en <= odd_lane(proc_addr);
                end
                DBA_REMOTE: begin
                    buf0_en <= host_go && !host_odd;
                    buf1_en <= host_go && host_odd;
                    xcvr1_en <= host_go && host_odd; // [RULE8]
                end
                default: begin
                    buf0_en <= 1'b0;
                    buf1_en <= 1'b0;
                    xcvr1_en <= 1'b0;
                end
            endcase
        end
    end

    // pin synchronisers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_s1_r <= 1'b0;
            idx_s2_r <= 1'b0;
            st_s1_r <= '0;
            st_s2_r <= '0;
            rg_s1_r <= 1'b0;
            rg_s2_r <= 1'b0;
            wg_s1_r <= 1'b0;
            wg_s2_r <= 1'b0;
        end else begin
            idx_s1_r <= index_pin;
            idx_s2_r <= idx_s1_r;
            st_s1_r <= drive_status_pin;
            st_s2_r <= st_s1_r;
            rg_s1_r <= read_gate_req;
            rg_s2_r <= rg_s1_r;
            wg_s1_r <= write_gate;
            wg_s2_r <= wg_s1_r;
        end
    end

    // index divider and panel lamps
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_d_r <= 1'b0;
            idx_cnt_r <= '0;
            led_green <= 1'b0;
            led_red <= 1'b0;
        end else begin
            idx_d_r <= idx_s2_r;
            if (idx_s2_r && !idx_d_r) begin
                idx_cnt_r <= (idx_cnt_r == IDX_CW'(IDX_DIV-1)) ? '0 : idx_cnt_r + 1'b1; // [RULE12]
            end
            led_green <= idx_cnt_r[IDX_CW-1]; // [RULE13]
            led_red <= idx_cnt_r[IDX_CW-1];
        end
    end

    // control and status bit registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive_ctrl <= CTRL_RST;
            drive_status <= '0;
        end else begin
            if (ctrl_we) begin
                drive_ctrl <= ctrl_wdata; // [RULE14]
            end
            drive_status <= st_s2_r; // [RULE14]
        end
    end

    // read gate waits out the splice after write gate falls
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rg_cnt_r <= '0;
            read_gate <= 1'b0;
        end else begin
            if (wg_s2_r || !rg_s2_r) begin
                rg_cnt_r <= '0; // [RULE11]
                read_gate <= 1'b0;
            end else if (rg_cnt_r < RG_CW'(RG_CYC)) begin
                rg_cnt_r <= rg_cnt_r + 1'b1;
                read_gate <= 1'b0;
            end else begin
                read_gate <= 1'b1; // [RULE11]
            end
        end
    end
endmodule

/* File: dv/dba_arbiter_sva.sv */
// checker: port assertions for the dma buffer arbiter
`timescale 1ns/1ns
module dba_arbiter_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // requests and grants
    input wire logic local_req,
    input wire logic proc_req,
    input wire logic local_gnt,
    input wire logic proc_gnt,
    input wire logic remote_gnt,
    input wire logic local_ack,
    input wire logic remote_ready,
    input wire logic remote_eom,
    // lanes and lamps
    input wire logic buf0_en,
    input wire logic buf1_en,
    input wire logic xcvr1_en,
    input wire logic led_green,
    input wire logic led_red
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_one_grant: assert property ($onehot0({local_gnt, proc_gnt, remote_gnt}))
        else $error("more than one grant");
    a_local_first: assert property (local_req |=> local_gnt)
        else $error("local request not granted");
    a_remote_last: assert property (remote_gnt |-> !$past(local_req) && !$past(proc_req))
        else $error("remote granted over a higher request");
    a_local_ack: assert property (local_gnt |=> local_ack)
        else $error("local access not acknowledged");
    a_wide_lanes: assert property (local_ack |-> buf0_en && buf1_en && xcvr1_en)
        else $error("local access not on both lanes");
    a_even_off: assert property (buf0_en && !buf1_en |-> !xcvr1_en)
        else $error("lane one on for even byte");
    a_eom_stop: assert property (remote_eom |-> !remote_ready)
        else $error("host bytes taken after end of message");
    a_leds_same: assert property (led_green == led_red)
        else $error("lamps differ");
endmodule
bind dba_arbiter dba_arbiter_sva i_dba_arbiter_sva (.clk, .rstn, .local_req, .proc_req, .local_gnt, .proc_gnt,
    .remote_gnt, .local_ack, .remote_ready, .remote_eom, .buf0_en, .buf1_en, .xcvr1_en, .led_green, .led_red);

/* File: dv/dba_host_model.sv */
// model: host chip byte source on the remote stream
`timescale 1ns/1ns
module dba_host_model (
    // clock
    input wire logic clk,
    // byte stream
    input wire logic ready,
    output logic valid,
    output logic eoi,
    output logic [7:0] data
);
    initial begin
        {valid, eoi, data} = 10'h0;
    end
    // offer a byte, held until taken or given up
    task automatic send(input logic [8:0] w, output logic ok);
        int n;
        n = 0;
        valid <= 1'b1;
        {eoi, data} <= w;
        do begin
            @(negedge clk);
            n++;
        end while (ready !== 1'b1 && n < 12);
        ok = ready;
        @(posedge clk);
    endtask
    // released lines show the inverse of the last byte
    task automatic stop();
        valid <= 1'b0;
        eoi <= ~eoi;
        data <= ~data;
    endtask
endmodule

/* File: dv/testbench.sv */
// bench: directed scenarios for the dma buffer arbiter
`timescale 1ns/1ns
module testbench;
    import dba_pkg::*;
    localparam int RGC = 2;
    logic clk, rstn, local_req, local_we, local_gnt, local_ack, proc_req, proc_we, proc_gnt, proc_ack, ok;
    logic remote_req, remote_valid, remote_eoi, remote_ready, remote_gnt, remote_eom, buf0_en, buf1_en, xcvr1_en;
    logic index_pin, read_gate_req, write_gate, ctrl_we, read_gate, led_green, led_red;
    logic [BUF_AW-1:0] local_addr, remote_base;
    logic [BUF_AW:0] proc_addr;
    logic [WORD_W-1:0] local_wdata, local_rdata, q;
    logic [7:0] proc_wdata, proc_rdata, remote_data, ctrl_wdata, drive_status_pin, drive_ctrl, drive_status;
    int err_count = 0;
    int samples_checked = 0;
    dba_arbiter #(.RG_CYC(RGC)) i_dba_arbiter (.clk, .rstn, .local_req, .local_we, .local_addr, .local_wdata,
        .local_gnt, .local_rdata, .local_ack, .proc_req, .proc_we, .proc_addr, .proc_wdata, .proc_gnt,
        .proc_rdata, .proc_ack, .remote_req, .remote_base, .remote_valid, .remote_data, .remote_eoi,
        .remote_ready, .remote_gnt, .remote_eom, .buf0_en, .buf1_en, .xcvr1_en, .index_pin, .read_gate_req,
        .write_gate, .ctrl_wdata, .ctrl_we, .drive_status_pin, .drive_ctrl, .drive_status, .read_gate,
        .led_green, .led_red);
    dba_host_model i_dba_host_model (.clk, .ready(remote_ready), .valid(remote_valid), .eoi(remote_eoi),
        .data(remote_data));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checked=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one access by local (l=1) or processor; read data lands in q
    task automatic acc(input logic l, input logic we, input logic [13:0] a, input logic [15:0] d);
        int n;
        n = 0;
        {local_req, proc_req, local_we, proc_we} <= {l, !l, we, we};
        {local_addr, proc_addr, local_wdata, proc_wdata} <= {a[12:0], a, d, d[7:0]};
        do begin
            @(negedge clk);
            n++;
        end while ((l ? local_ack : proc_ack) !== 1'b1 && n < 20);
        q = l ? local_rdata : 16'(proc_rdata);
        @(posedge clk);
        {local_req, proc_req} <= 2'b00;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_local();
        acc(1'b1, 1'b1, 14'h0003, 16'hBEEF);
        acc(1'b1, 1'b0, 14'h0003, 16'h0);
        chk(q, 16'hBEEF);
        acc(1'b0, 1'b0, 14'h0006, 16'h0);
        chk(q, 16'h00EF);
        acc(1'b0, 1'b0, 14'h0007, 16'h0);
        chk(q, 16'h00BE);
        {local_req, proc_req} <= 2'b11;
        repeat (2) @(negedge clk);
        chk(16'({local_gnt, proc_gnt}), 16'h0002);
        @(posedge clk);
        local_req <= 1'b0;
        repeat (2) @(negedge clk);
        chk(16'({local_gnt, proc_gnt}), 16'h0001);
        @(posedge clk);
        proc_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_host();
        int k;
        acc(1'b0, 1'b1, 14'h0028, 16'h005A);
        remote_base <= 13'h0010;
        // processor holds the bus so the fifo can only fill
        {remote_req, proc_req} <= 2'b11;
        for (k = 0; k < 9; k++) begin
            i_dba_host_model.send({k == 7, 8'hA0 + 8'(k)}, ok);
            chk(16'(ok), 16'(k < 8));
        end
        i_dba_host_model.stop();
        proc_req <= 1'b0;
        repeat (3) @(negedge clk);
        chk(16'({remote_gnt, buf0_en, buf1_en, xcvr1_en}), 16'h000C);
        @(negedge clk);
        chk(16'({remote_gnt, buf0_en, buf1_en, xcvr1_en}), 16'h000B);
        repeat (36) @(posedge clk);
        chk(16'({remote_eom, remote_ready}), 16'h0002);
        i_dba_host_model.send(9'h0FF, ok);
        chk(16'(ok), 16'h0);
        i_dba_host_model.stop();
        remote_req <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 9; k++) begin
            acc(1'b0, 1'b0, 14'h0020 + 14'(k), 16'h0);
            chk(q, k < 8 ? 16'h00A0 + 16'(k) : 16'h005A);
        end
    endtask
    task automatic t_pins();
        int k;
        {ctrl_wdata, drive_status_pin, ctrl_we, read_gate_req} <= {8'hC3, 8'h96, 2'b11};
        @(posedge clk);
        ctrl_we <= 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(read_gate), 16'h0);
        repeat (RGC + 6) @(negedge clk);
        chk(16'(read_gate), 16'h1);
        chk({drive_ctrl, drive_status}, 16'hC396);
        for (k = 1; k <= 4; k++) begin
            @(posedge clk);
            {index_pin, write_gate} <= 2'b11;
            repeat (4) @(posedge clk);
            index_pin <= 1'b0;
            repeat (4) @(negedge clk);
            chk(16'(led_green), 16'(k[1]));
        end
        chk(16'(read_gate), 16'h0);
    endtask
    initial begin
        {rstn, local_req, local_we, proc_req, proc_we, remote_req, index_pin, read_gate_req} = '0;
        {write_gate, ctrl_we, local_addr, remote_base, proc_addr, local_wdata, proc_wdata} = '0;
        {ctrl_wdata, drive_status_pin} = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_local();
        t_host();
        t_pins();
        summarize();
    end
    initial begin
        #100000;
        err_count++;
        summarize();
    end
endmodule
